// ===== mmpd_pkg.sv
package mmpd_pkg;

	localparam int          PC_W        = 10;
	localparam int          STACK_DEPTH = 8;
	localparam int          GPR_WORDS   = 48;
	localparam logic [9:0]  VEC_RESET   = 10'h000;
	localparam logic [9:0]  VEC_SW_IRQ  = 10'h001;
	localparam logic [9:0]  VEC_HW_IRQ  = 10'h008;
	localparam logic [5:0]  GPR_FIRST   = 6'h10;
	localparam logic [5:0]  GPR_LAST    = 6'h3F;

	// main page
	localparam logic [3:0]  R_INDIRECT  = 4'h0;
	localparam logic [3:0]  R_TIMER0    = 4'h1;
	localparam logic [3:0]  R_PCL       = 4'h2;
	localparam logic [3:0]  R_STATUS    = 4'h3;
	localparam logic [3:0]  R_FSR       = 4'h4;
	localparam logic [3:0]  R_PORT_B_DATA     = 4'h6;
	localparam logic [3:0]  R_POWER_CONTROL      = 4'h8;
	localparam logic [3:0]  R_WAKEUP    = 4'h9;
	localparam logic [3:0]  R_PROGRAM_COUNTER_HIGH_BUFFER    = 4'hA;
	localparam logic [3:0]  R_PULLDN    = 4'hB;
	localparam logic [3:0]  R_PULLUP    = 4'hC;
	localparam logic [3:0]  R_IRQ_EN    = 4'hE;
	localparam logic [3:0]  R_IRQ_FLAG  = 4'hF;
	// configuration page
	localparam logic [3:0]  C_DIR       = 4'h6;
	localparam logic [3:0]  C_PRESCALE0 = 4'hA;
	localparam logic [3:0]  C_OPENDRAIN = 4'hC;
	localparam logic [3:0]  C_POWER_CONTROL_EXT  = 4'hF;
	// function page
	localparam logic [3:0]  F_TIMER1    = 4'h0;
	localparam logic [3:0]  F_T1CTL_A   = 4'h1;
	localparam logic [3:0]  F_T1CTL_B   = 4'h2;
	localparam logic [3:0]  F_PWM_DUTY  = 4'h3;
	localparam logic [3:0]  F_PRESCALE1 = 4'h4;
	localparam logic [3:0]  F_BUZZER    = 4'h5;
	localparam logic [3:0]  F_INFRARED  = 4'h6;
	localparam logic [3:0]  F_TBL_PTR   = 4'h7;
	localparam logic [3:0]  F_TBL_DATA  = 4'h8;
	localparam logic [3:0]  F_OSC       = 4'hF;

	// one bit per address that holds storage
	localparam logic [15:0] R_IMPL      = 16'hDF5E;
	localparam logic [15:0] C_IMPL      = 16'h9440;
	localparam logic [15:0] F_IMPL      = 16'h81FF;

	localparam int          BANK_LSB    = 6;
	localparam int          POWER_CONTROL_EIS    = 6;
	localparam int          INTERRUPT_ENABLE_MASK_EXT    = 2;
	localparam int          FUNCPAGE_INFRARED_CONTROL_EN     = 0;

	localparam logic [7:0]  RST_STATUS  = 8'h18;
	localparam logic [7:0]  RST_POWER_CONTROL    = 8'h88;
	localparam logic [7:0]  RST_WAKEUP  = 8'h3F;
	localparam logic [7:0]  RST_DIR     = 8'h3F;
	localparam logic [7:0]  RST_OTHER   = 8'h00;

	typedef enum logic [3:0] {
		PC_STEP, PC_HOLD, PC_SHORT, PC_MEDIUM, PC_LONG,
		PC_CALL_SHORT, PC_CALL_LONG, PC_RETURN, PC_SW_IRQ, PC_HW_IRQ
	} mmpd_pc_op_t;

	typedef enum logic [1:0] {PAGE_MAIN, PAGE_CFG, PAGE_FUNC} mmpd_page_t;

	typedef enum logic [1:0] {P2_GPIO, P2_TCLK, P2_PWM, P2_BUZZ} mmpd_pin2_t;

	typedef struct packed {
		mmpd_pc_op_t op;
		logic [9:0]  target;
	} mmpd_pc_req_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		mmpd_page_t  page;
		logic [5:0]  addr;
		logic [7:0]  wdata;
	} mmpd_data_req_t;

	function automatic logic [7:0] mmpd_reset_value(input logic [1:0] page, input logic [3:0] addr);
		logic [7:0] v;
		v = RST_OTHER;
		if (page == 2'(PAGE_MAIN) && addr == R_STATUS)
			v = RST_STATUS;
		if (page == 2'(PAGE_MAIN) && addr == R_POWER_CONTROL)
			v = RST_POWER_CONTROL;
		if (page == 2'(PAGE_MAIN) && addr == R_WAKEUP)
			v = RST_WAKEUP;
		if (page == 2'(PAGE_CFG) && addr == C_DIR)
			v = RST_DIR;
		return v;
	endfunction

endpackage

// ===== mmpd_stack.sv
`timescale 1ns/1ps
module mmpd_stack
	import mmpd_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int W     = PC_W
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// stack operations
	input  wire logic         push,
	input  wire logic         pop,
	input  wire logic [W-1:0] push_data,
	output logic      [W-1:0] top
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] ptr;

	// circular: a ninth push silently overwrites the oldest entry, as the core expects
	always_ff @(posedge mclk) begin
		if (reset) begin
			ptr <= '0;
		end else if (push) begin
			ptr <= ptr + PW'(1);
		end else if (pop) begin
			ptr <= ptr - PW'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end else if (push) begin
			mem[ptr + PW'(1)] <= push_data;
		end
	end

	assign top = mem[ptr];

endmodule

// ===== mmpd_core.sv
`timescale 1ns/1ps
// How it works
// - program counter is 10 bits, covering all 1K program words
// - reset starts fetching at address 0x000
// - software interrupt jumps to 0x001
// - every hardware interrupt jumps to shared address 0x008
// - short forms reach 256 words, medium jump 512, long forms everything
// - calls and interrupts push next address; returns pop it into the counter
// - pointer bits 7:6 form the bank field; all four banks reach the same storage
// - indirect port redirects to pointer low six bits in the selected bank
// - direct access uses opcode low six bits only; the bank field is not used
// - special registers 0x0-0xF exist in bank 0; other banks mirror them
// - general RAM 0x10-0x3F; other banks map back to bank 0
// - configuration page is reached only by its two dedicated instructions
// - function page is reached only by its two dedicated instructions
// - both dedicated pages ignore the bank field
// - pin 0 is interrupt input only when select and enable bits are both 1
// - infrared mode puts the carrier on pin 1
// - pin 2 can be timer clock in, PWM out or buzzer out
// - pin 3 is input or open-drain only; as reset pin, low resets device
// - pin 4 can drive out the instruction clock
// - indirect port has no storage; it acts on the pointed register
// - bank field never changes which physical storage is reached
module mmpd_core
	import mmpd_pkg::*;
(
	// clock and reset
	input  wire logic           mclk,
	input  wire logic           reset,
	// program flow from the execution unit
	input  wire mmpd_pc_req_t   pc_req,
	output logic [PC_W-1:0]     program_counter,
	// data access from the execution unit
	input  wire mmpd_data_req_t data_req,
	output logic [7:0]          rdata,
	// configuration word and peripheral sources
	input  wire logic           read_pin_on_output,
	input  wire mmpd_pin2_t     pin2_func,
	input  wire logic           reset_pin_enable,
	input  wire logic           insn_clk_out_enable,
	input  wire logic           insn_clk,
	input  wire logic           infrared_carrier,
	input  wire logic           pwm_source,
	input  wire logic           buzzer_source,
	// port pins
	input  wire logic [5:0]     pin_in,
	output logic      [5:0]     pin_out,
	output logic      [5:0]     pin_oe_n,
	// decoded pin functions
	output logic                ext_irq_level,
	output logic                ext_timer_clock_in,
	output logic                reset_pin_low
);

	logic [7:0]      special_register [3][16];
	logic [7:0]      general_ram [GPR_WORDS];
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] pc_plus1;
	logic [PC_W-1:0] stack_top;
	logic            push;
	logic            pop;
	logic [5:0]      eff_addr;
	logic [5:0]      gpr_index;
	logic            gpr_hit;
	logic            sfr_hit;
	logic [3:0]      sfr_addr;
	logic [7:0]      next_rdata;
	logic [7:0]      port_view;
	logic [5:0]      next_out;
	logic [5:0]      next_oe_n;
	logic            ext_irq_sel;
	logic            ir_mode;
	logic [5:0]      dir_in;
	logic [5:0]      open_drain;
	logic [5:0]      latch;

	assign pc_plus1 = program_counter + PC_W'(1);

	// ---------------- program counter ----------------

	always_comb begin
		push    = 1'b0;
		pop     = 1'b0;
		next_pc = pc_plus1;
		unique case (pc_req.op)
			PC_STEP: begin
				// a write to the counter low byte is a computed jump
				if (data_req.wr && data_req.page == PAGE_MAIN && sfr_hit && sfr_addr == R_PCL)
					next_pc = {special_register[PAGE_MAIN][R_PROGRAM_COUNTER_HIGH_BUFFER][1:0], data_req.wdata};
			end
			PC_HOLD: next_pc = program_counter;
			PC_SHORT: next_pc = {special_register[PAGE_MAIN][R_PROGRAM_COUNTER_HIGH_BUFFER][1:0], pc_req.target[7:0]};
			PC_MEDIUM: next_pc = {special_register[PAGE_MAIN][R_PROGRAM_COUNTER_HIGH_BUFFER][1], pc_req.target[8:0]};
			PC_LONG: next_pc = pc_req.target;
			PC_CALL_SHORT: begin
				next_pc = {special_register[PAGE_MAIN][R_PROGRAM_COUNTER_HIGH_BUFFER][1:0], pc_req.target[7:0]};
				push    = 1'b1;
			end
			PC_CALL_LONG: begin
				next_pc = pc_req.target;
				push    = 1'b1;
			end
			PC_RETURN: begin
				next_pc = stack_top;
				pop     = 1'b1;
			end
			PC_SW_IRQ: begin
				next_pc = VEC_SW_IRQ;
				push    = 1'b1;
			end
			PC_HW_IRQ: begin
				next_pc = VEC_HW_IRQ;
				push    = 1'b1;
			end
			// spare op codes fall back to a plain step rather than freezing fetch
			default: ;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset)
			program_counter <= VEC_RESET;
		else
			program_counter <= next_pc;
	end

	mmpd_stack #(
		.DEPTH(STACK_DEPTH),
		.W    (PC_W)
	) u_stack (
		.mclk     (mclk),
		.reset    (reset),
		.push     (push),
		.pop      (pop),
		.push_data(pc_plus1),
		.top      (stack_top)
	);

	// ---------------- data address decode ----------------

	always_comb begin
		// bank field bits 7:6 are kept but never steer the decode: one physical bank
		eff_addr = data_req.addr;
		if (data_req.page == PAGE_MAIN && data_req.addr == {2'b00, R_INDIRECT})
			eff_addr = special_register[PAGE_MAIN][R_FSR][5:0];
		// dedicated pages decode only addresses below 0x10; higher ones hit nothing; bank bits ignored
		sfr_addr = eff_addr[3:0];
		sfr_hit  = 1'b0;
		gpr_hit  = 1'b0;
		unique case (data_req.page)
			PAGE_MAIN: begin
				sfr_hit = eff_addr < GPR_FIRST && R_IMPL[sfr_addr];
				gpr_hit = eff_addr >= GPR_FIRST && eff_addr <= GPR_LAST;
			end
			PAGE_CFG: sfr_hit = eff_addr < GPR_FIRST && C_IMPL[sfr_addr];
			PAGE_FUNC: sfr_hit = eff_addr < GPR_FIRST && F_IMPL[sfr_addr];
			default: ;
		endcase
		gpr_index = eff_addr - GPR_FIRST;
	end

	// ---------------- register storage ----------------

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int p = 0; p < 3; p++)
				for (int a = 0; a < 16; a++)
					special_register[p][a] <= mmpd_reset_value(2'(p), 4'(a));
		end else if (data_req.wr && sfr_hit) begin
			special_register[data_req.page][sfr_addr] <= data_req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (data_req.wr && gpr_hit)
			general_ram[gpr_index] <= data_req.wdata;
	end

	// ---------------- read path ----------------

	// input pins read the pad; output pins read pad or latch per configuration word
	always_comb begin
		port_view = special_register[PAGE_MAIN][R_PORT_B_DATA];
		for (int i = 0; i < 6; i++)
			if (dir_in[i] || read_pin_on_output)
				port_view[i] = pin_in[i];
	end

	always_comb begin
		next_rdata = 8'h00;
		if (gpr_hit)
			next_rdata = general_ram[gpr_index];
		else if (sfr_hit)
			next_rdata = special_register[data_req.page][sfr_addr];
		if (data_req.page == PAGE_MAIN && sfr_hit && sfr_addr == R_PCL)
			next_rdata = program_counter[7:0];
		if (data_req.page == PAGE_MAIN && sfr_hit && sfr_addr == R_PORT_B_DATA)
			next_rdata = port_view;
	end

	always_ff @(posedge mclk) begin
		if (reset)
			rdata <= 8'h00;
		else if (data_req.rd)
			rdata <= next_rdata;
	end

	// ---------------- pin functions ----------------

	assign latch       = special_register[PAGE_MAIN][R_PORT_B_DATA][5:0];
	assign dir_in      = special_register[PAGE_CFG][C_DIR][5:0];
	assign open_drain  = special_register[PAGE_CFG][C_OPENDRAIN][5:0];
	assign ext_irq_sel = special_register[PAGE_MAIN][R_POWER_CONTROL][POWER_CONTROL_EIS] & special_register[PAGE_MAIN][R_IRQ_EN][INTERRUPT_ENABLE_MASK_EXT];
	assign ir_mode     = special_register[PAGE_FUNC][F_INFRARED][FUNCPAGE_INFRARED_CONTROL_EN];

	always_comb begin
		logic [5:0] drive;
		drive    = '0;
		next_out = latch;
		for (int i = 0; i < 6; i++)
			drive[i] = ~dir_in[i];
		if (ext_irq_sel)
			drive[0] = 1'b0;
		if (ir_mode) begin
			drive[1]    = 1'b1;
			next_out[1] = infrared_carrier;
		end
		unique case (pin2_func)
			P2_GPIO: ;
			P2_TCLK: drive[2] = 1'b0;
			P2_PWM: begin
				drive[2]    = 1'b1;
				next_out[2] = pwm_source;
			end
			P2_BUZZ: begin
				drive[2]    = 1'b1;
				next_out[2] = buzzer_source;
			end
		endcase
		if (reset_pin_enable)
			drive[3] = 1'b0;
		if (insn_clk_out_enable) begin
			drive[4]    = 1'b1;
			next_out[4] = insn_clk;
		end
		// open drain: only a low is driven; a high floats to the pull resistor
		for (int i = 0; i < 6; i++)
			if (open_drain[i] || i == 3)
				drive[i] = drive[i] & ~next_out[i];
		next_oe_n = ~drive;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out  <= next_out;
			pin_oe_n <= next_oe_n;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ext_irq_level      <= 1'b0;
			ext_timer_clock_in <= 1'b0;
			reset_pin_low      <= 1'b0;
		end else begin
			ext_irq_level      <= ext_irq_sel & pin_in[0];
			ext_timer_clock_in <= (pin2_func == P2_TCLK) & pin_in[2];
			reset_pin_low      <= reset_pin_enable & ~pin_in[3];
		end
	end

	// ---------------- checks ----------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	reset_vector_a: assert property ($fell(reset) |-> program_counter == 10'h000)
		else $error("counter not at reset vector");
	sw_vector_a: assert property (pc_req.op == PC_SW_IRQ |=> program_counter == 10'h001)
		else $error("software interrupt vector wrong");
	hw_vector_a: assert property (pc_req.op == PC_HW_IRQ |=> program_counter == 10'h008)
		else $error("hardware interrupt vector wrong");
	medium_reach_a: assert property (pc_req.op == PC_MEDIUM |=> program_counter[8:0] == $past(pc_req.target[8:0]))
		else $error("medium jump target wrong");
	call_return_a: assert property (pc_req.op == PC_CALL_LONG ##1 pc_req.op == PC_RETURN
		|=> program_counter == $past(program_counter, 2) + 10'h001)
		else $error("return address wrong");
	bank_mirror_a: assert property (data_req.wr && data_req.page == PAGE_MAIN && data_req.addr >= 6'h10
		##1 data_req.rd && data_req.page == PAGE_MAIN && data_req.addr == $past(data_req.addr)
		&& !data_req.wr |=> rdata == $past(data_req.wdata, 2))
		else $error("ram mirror read back wrong");
	unused_zero_a: assert property (data_req.rd && data_req.page == PAGE_MAIN && data_req.addr == 6'h05
		|=> rdata == 8'h00)
		else $error("unassigned address not zero");
	irq_pin_a: assert property (ext_irq_sel |=> pin_oe_n[0])
		else $error("pin 0 driven in interrupt mode");
	open_drain3_a: assert property (!pin_oe_n[3] |-> !pin_out[3])
		else $error("pin 3 driven high");
	reset_pin_a: assert property (reset_pin_enable && !pin_in[3] |=> reset_pin_low)
		else $error("reset pin low not reported");

	// program flow
	step_count_a: assert property (pc_req.op == PC_STEP && !data_req.wr
		|=> program_counter == $past(program_counter) + 10'h001)
		else $error("counter did not step by one");
	hold_still_a: assert property (pc_req.op == PC_HOLD |=> program_counter == $past(program_counter))
		else $error("counter moved while held");
	short_reach_a: assert property (pc_req.op inside {PC_SHORT, PC_CALL_SHORT}
		|=> program_counter[7:0] == $past(pc_req.target[7:0]))
		else $error("short target wrong");
	long_reach_a: assert property (pc_req.op inside {PC_LONG, PC_CALL_LONG}
		|=> program_counter == $past(pc_req.target))
		else $error("long target wrong");

	// data access
	indirect_write_a: assert property (data_req.wr && data_req.page == PAGE_MAIN && data_req.addr == 6'h00
		&& special_register[PAGE_MAIN][R_FSR][5:0] == 6'h0B
		|=> special_register[PAGE_MAIN][R_PULLDN] == $past(data_req.wdata))
		else $error("indirect write missed its target");
	indirect_empty_a: assert property (data_req.rd && data_req.page == PAGE_MAIN && data_req.addr == 6'h00
		&& special_register[PAGE_MAIN][R_FSR][5:0] == 6'h00 |=> rdata == 8'h00)
		else $error("indirect port read back storage");
	unused_holes_a: assert property (data_req.rd && data_req.page == PAGE_MAIN
		&& data_req.addr inside {6'h07, 6'h0D} |=> rdata == 8'h00)
		else $error("unassigned address not zero");
	page_high_zero_a: assert property (data_req.rd && data_req.page != PAGE_MAIN && data_req.addr >= 6'h10
		|=> rdata == 8'h00)
		else $error("dedicated page reached past its registers");

	// pins
	irq_idle_a: assert property (!ext_irq_sel |=> !ext_irq_level)
		else $error("interrupt level raised while pin 0 is plain");
	carrier_pin_a: assert property (ir_mode |=> pin_out[1] == $past(infrared_carrier))
		else $error("carrier not on pin 1");
	tclk_input_a: assert property (pin2_func == P2_TCLK |=> pin_oe_n[2])
		else $error("pin 2 driven in timer clock mode");
	reset_input_a: assert property (reset_pin_enable |=> pin_oe_n[3])
		else $error("pin 3 driven as reset pin");
	clock_out_a: assert property (insn_clk_out_enable |=> pin_out[4] == $past(insn_clk))
		else $error("instruction clock not on pin 4");

endmodule

// ===== mmpd_cpu_model.sv
`timescale 1ns/1ps
module mmpd_cpu_model
	import mmpd_pkg::*;
(
	// clock
	input  wire logic     mclk,
	// requests to the block
	output mmpd_pc_req_t   pc_req,
	output mmpd_data_req_t data_req
);
	initial begin
		pc_req   = '{PC_HOLD, 10'h000};
		data_req = '0;
	end

	// one request per cycle, launched just after an edge and held until the next
	task automatic issue(input mmpd_pc_op_t op, input logic [9:0] tgt, input logic rd, input logic wr,
		input mmpd_page_t pg, input logic [5:0] ad, input logic [7:0] wd);
		@(posedge mclk);
		#1;
		pc_req   = '{op, tgt};
		data_req = '{rd, wr, pg, ad, wd};
	endtask

	// holding keeps the counter still so reads see a known value
	task automatic idle();
		issue(PC_HOLD, 10'h000, 1'b0, 1'b0, PAGE_MAIN, 6'h00, 8'h00);
	endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	import mmpd_pkg::*;
	logic           mclk;
	logic           reset;
	mmpd_pc_req_t   pc_req;
	mmpd_data_req_t data_req;
	logic [9:0]     program_counter;
	logic [7:0]     rdata;
	logic           rd_pad;
	mmpd_pin2_t     p2f;
	logic           rst_en;
	logic           ck_en;
	logic [3:0]     src;
	logic [5:0]     pin_in;
	logic [5:0]     pin_out;
	logic [5:0]     pin_oe_n;
	logic           irq_lvl;
	logic           tclk;
	logic           rst_low;
	int             fails;
	int             checks_done;
	int             k;
	logic [7:0]     regs [3][16];
	logic [9:0]     pc;
	logic [9:0]     t;
	logic [9:0]     stk [$];
	mmpd_pc_op_t    op;
	logic [1:0]     pg;
	logic [5:0]     a;
	logic [7:0]     d;
	logic           e2;

	mmpd_cpu_model i_cpu (.mclk(mclk), .pc_req(pc_req), .data_req(data_req));

	mmpd_core i_dut (.mclk(mclk), .reset(reset), .pc_req(pc_req), .program_counter(program_counter),
		.data_req(data_req), .rdata(rdata), .read_pin_on_output(rd_pad), .pin2_func(p2f),
		.reset_pin_enable(rst_en), .insn_clk_out_enable(ck_en), .insn_clk(src[3]),
		.infrared_carrier(src[2]), .pwm_source(src[1]), .buzzer_source(src[0]), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_irq_level(irq_lvl), .ext_timer_clock_in(tclk),
		.reset_pin_low(rst_low));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic finish_test();
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input mmpd_page_t pa, input logic [5:0] ad, input logic [7:0] wd);
		i_cpu.issue(PC_HOLD, 10'h000, 1'b0, 1'b1, pa, ad, wd);
		i_cpu.idle();
	endtask

	task automatic rd(input mmpd_page_t pa, input logic [5:0] ad, input logic [7:0] exp);
		i_cpu.issue(PC_HOLD, 10'h000, 1'b1, 1'b0, pa, ad, 8'h00);
		i_cpu.idle();
		chk(16'(rdata), 16'(exp));
	endtask

	// storage map per page: main, configuration, function
	function automatic logic [7:0] expv(input int p, input int ad);
		logic [15:0] m;
		m = (p == 0) ? 16'hDF5E : (p == 1) ? 16'h9440 : 16'h81FF;
		if (ad > 15 || !m[ad])
			return 8'h00;
		return regs[p][ad];
	endfunction

	initial begin
		#1000000;
		fails++;
		finish_test();
	end

	initial begin
		reset = 1'b1;
		pin_in = 6'h00;
		p2f = P2_GPIO;
		rst_en = 1'b0;
		ck_en = 1'b0;
		src = 4'h0;
		rd_pad = 1'b0;
		fails = 0;
		checks_done = 0;
		void'($urandom(13));
		foreach (regs[i, j])
			regs[i][j] = 8'h00;
		regs[0][3] = 8'h18;
		regs[0][8] = 8'h88;
		regs[0][9] = 8'h3F;
		regs[1][6] = 8'h3F;
		repeat (3) @(posedge mclk);
		#1;
		reset = 1'b0;
		rd_pad = 1'($urandom);
		chk(16'(pin_oe_n), 16'h003F);
		// pins are inputs at reset, so the port view reads the zero pads
		for (k = 0; k < 48; k++)
			rd(mmpd_page_t'(2'(k / 16)), 6'(k % 16), expv(k / 16, k % 16));
		chk(16'(program_counter), 16'h0000);
		for (k = 0; k < 60; k++) begin
			pg = 2'($urandom_range(2));
			a = 6'($urandom);
			d = 8'($urandom);
			if (pg == 2'd0 && (a > 6'h0F || a inside {6'h00, 6'h02, 6'h04, 6'h06}))
				a = 6'h0C;
			wr(PAGE_MAIN, 6'h04, 8'($urandom));
			wr(mmpd_page_t'(pg), a, d);
			if (a < 6'h10)
				regs[pg][a[3:0]] = d;
			wr(PAGE_MAIN, 6'h04, 8'($urandom));
			rd(mmpd_page_t'(pg), a, expv(pg, a));
		end
		for (k = 0; k < 40; k++) begin
			a = 6'($urandom_range(63, 16));
			d = 8'($urandom);
			wr(PAGE_MAIN, 6'h04, {2'($urandom), a});
			wr(PAGE_MAIN, k[0] ? 6'h00 : a, d);
			wr(PAGE_MAIN, 6'h04, {2'($urandom), a});
			rd(PAGE_MAIN, k[0] ? a : 6'h00, d);
		end
		// write then read in the next cycle, as the execution unit may do
		a = 6'($urandom_range(63, 16));
		d = 8'($urandom);
		i_cpu.issue(PC_HOLD, 10'h000, 1'b0, 1'b1, PAGE_MAIN, a, d);
		i_cpu.issue(PC_HOLD, 10'h000, 1'b1, 1'b0, PAGE_MAIN, a, 8'h00);
		i_cpu.idle();
		chk(16'(rdata), 16'(d));
		wr(PAGE_MAIN, 6'h04, 8'hCB);
		wr(PAGE_MAIN, 6'h00, 8'h5A);
		rd(PAGE_MAIN, 6'h0B, 8'h5A);
		wr(PAGE_MAIN, 6'h04, 8'h40);
		rd(PAGE_MAIN, 6'h00, 8'h00);
		rd(PAGE_MAIN, 6'h04, 8'h40);
		d = 8'($urandom);
		wr(PAGE_MAIN, 6'h0A, d);
		pc = program_counter;
		for (k = 0; k < 80; k++) begin
			t = 10'($urandom);
			op = mmpd_pc_op_t'(4'($urandom_range(9)));
			if (k == 0) begin
				op = PC_LONG;
				t = 10'h3FF;
			end
			if (k == 1)
				op = PC_STEP;
			if (op == PC_RETURN && stk.size() == 0)
				op = PC_CALL_LONG;
			if (op inside {PC_CALL_SHORT, PC_CALL_LONG, PC_SW_IRQ, PC_HW_IRQ} && stk.size() == 8)
				op = PC_RETURN;
			if (op inside {PC_CALL_SHORT, PC_CALL_LONG, PC_SW_IRQ, PC_HW_IRQ})
				stk.push_back(pc + 10'd1);
			case (op)
				PC_STEP: pc = pc + 10'd1;
				PC_SHORT, PC_CALL_SHORT: pc = {d[1:0], t[7:0]};
				PC_MEDIUM: pc = {d[1], t[8:0]};
				PC_LONG, PC_CALL_LONG: pc = t;
				PC_RETURN: pc = stk.pop_back();
				PC_SW_IRQ: pc = 10'h001;
				PC_HW_IRQ: pc = 10'h008;
				default: ;
			endcase
			i_cpu.issue(op, t, 1'b0, 1'b0, PAGE_MAIN, 6'h00, 8'h00);
			i_cpu.idle();
			chk(16'(program_counter), 16'(pc));
		end
		// call straight into return: the pushed address comes back at once
		t = 10'($urandom);
		i_cpu.issue(PC_CALL_LONG, t, 1'b0, 1'b0, PAGE_MAIN, 6'h00, 8'h00);
		i_cpu.issue(PC_RETURN, 10'h000, 1'b0, 1'b0, PAGE_MAIN, 6'h00, 8'h00);
		i_cpu.idle();
		pc = pc + 10'd1;
		chk(16'(program_counter), 16'(pc));
		// earlier random writes may have left pins open drain
		wr(PAGE_CFG, 6'h0C, 8'h00);
		wr(PAGE_CFG, 6'h06, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(PAGE_MAIN, 6'h08, k[1] ? 8'hC8 : 8'h88);
			wr(PAGE_MAIN, 6'h0E, {5'h00, k[0], 2'b00});
			pin_in = 6'($urandom);
			repeat (3) i_cpu.idle();
			chk({irq_lvl, pin_oe_n[0]}, {(k == 3) & pin_in[0], k == 3});
		end
		wr(PAGE_FUNC, 6'h06, 8'h01);
		// loop index picks pin 2 mode, reset-pin mode, clock output and latch of pin 3
		for (k = 0; k < 16; k++) begin
			p2f = mmpd_pin2_t'(k[1:0]);
			rst_en = k[2];
			ck_en = k[3];
			src = 4'($urandom);
			pin_in = 6'($urandom);
			wr(PAGE_MAIN, 6'h06, {4'h0, k[0], 3'h0});
			repeat (3) i_cpu.idle();
			e2 = (p2f == P2_PWM) ? src[1] : (p2f == P2_BUZZ) ? src[0] : 1'b0;
			chk({pin_out[1], pin_oe_n[1]}, {src[2], 1'b0});
			chk({tclk, pin_oe_n[2]}, {(p2f == P2_TCLK) & pin_in[2], p2f == P2_TCLK});
			chk(pin_out[2] | (p2f == P2_TCLK), e2 | (p2f == P2_TCLK));
			chk({pin_oe_n[3], rst_low}, {k[0] | rst_en, rst_en & ~pin_in[3]});
			chk({pin_out[4], pin_oe_n[4]}, {ck_en & src[3], 1'b0});
		end
		finish_test();
	end
endmodule
